// ### design/spb_serial_port.sv
/*
  Serial port with bit-rate timers: mode 0 shift register, mode 1 (and 3)
  ten-bit framing, timer 1 and timer 2 bit-rate sources, AXI4-Lite slave.
  Assumes sys_clk_in is the oscillator; pins are asynchronous to it.
*/
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Timer 1 bit rate is its overflow rate over 32, or 16 when doubled
// - Timer 1 eight-bit auto-reload counts machine cycles from reload byte
// - Transmit and receive clock selects each pick timer 2 independently
// - Timer 2 rollover reloads the full sixteen-bit count from reload pair
// - Timer 2 as bit-rate source counts every state time
// - Bit-rate rollover never sets the timer 2 overflow flag
// - External falling edge sets external flag; reloads only outside bit-rate mode
// - Mode 0 moves eight bits LSB first on data pin, clock on other
// - Mode 0 buffer write loads marker; send starts one cycle later
// - Mode 0 clock low in S3..S5; shift right at S6P2 while sending
// - Mode 0 send ends, transmit flag set at S1P1 of tenth cycle
// - Mode 0 receive starts with enable set and flag clear, preload
// - Mode 0 receive samples at S5P2, shifts at S6P2
// - Mode 0 receive loads buffer, sets flag at S1P1 of tenth cycle
// - Mode 1 frame: zero start, eight data LSB first, one stop bit
// - Mode 1 send starts after next divide-by-16 rollover following write
// - Mode 1 send ends, transmit flag set at tenth rollover
// - Mode 1 receiver oversamples sixteen times, restarts counter on edge
// - Two-of-three vote per bit; false start returns to hunting
// - Frame kept only if flag clear and stop valid when required
// - Buffer write feeds transmitter; buffer read returns receive register
module spb_serial_port
  import spb_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  output logic serial_clock_pin_out,
  input wire logic timer2_external_input_in,
  input wire logic timer2_count_pin_in
);
  spb_sctrl_t sctrl;
  spb_t2ctl_t t2ctl;
  spb_t1cfg_t t1cfg;
  spb_tx_state_t tx_state;
  spb_rx_state_t rx_state;
  logic [15:0] t2_count, t2_reload;
  logic [7:0] serial_buffer_rx;
  logic [3:0] ph, tx_div, rx_div;
  logic [8:0] tx_sh, rx_sh;
  logic [2:0] sync1, sync2, sync3, smp;
  logic aw_full, w_full, wr_en, t1_half, tx_data_on, tx_last, rx_last;
  logic rx_prev, m0_sample;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Synchronised pins: data, external edge input, timer 2 count pin
  wire din = sync2[0];
  wire timer2_external_input_fall = sync3[1] & ~sync2[1];
  wire t2pin_fall = sync3[2] & ~sync2[2];
  wire is_m0 = (sctrl.port_mode == SP_MODE_SHIFT);
  wire is_m1 = sctrl.port_mode[0];
  wire cyc_end = (ph == PH_S6P2);
  wire brg = t2ctl.rx_clock_select | t2ctl.transmit_clock_select;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sync3 <= 3'h7;
    end else begin
      sync1 <= {timer2_count_pin_in, timer2_external_input_in,
                serial_data_pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Machine-cycle phase counter, twelve oscillator clocks per cycle
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || cyc_end) begin
      ph <= PH_S1P1;
    end else begin
      ph <= ph + 4'h1;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready_out = ~aw_full;
  assign s_axi_wready_out = ~w_full;
  assign wr_en = aw_full & w_full & ~s_axi_bvalid_out;
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (aw_addr > ADDR_T1CFG || aw_addr[1:0] != 2'b00)
                           ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one cycle to rvalid; unmapped reads zero with SLVERR
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= RESP_OKAY;
      case (s_axi_araddr_in)
        ADDR_SCTRL: s_axi_rdata_out <= {24'h0, sctrl};
        ADDR_SBUFR: s_axi_rdata_out <= {24'h0, serial_buffer_rx};
        ADDR_T2CTL: s_axi_rdata_out <= {24'h0, t2ctl};
        ADDR_T2CNT: s_axi_rdata_out <= {16'h0, t2_count};
        ADDR_T2RLD: s_axi_rdata_out <= {16'h0, t2_reload};
        ADDR_T1CFG: s_axi_rdata_out <= {12'h0, t1cfg};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  wire wr_at = wr_en & w_strb[0];
  wire buf_wr = wr_at & (aw_addr == ADDR_SBUFR);

  // Timer 1: machine-cycle ticks, 8-bit auto-reload or plain 16-bit
  wire t1_inc = t1cfg.timer1_run & cyc_end;
  wire t1_ar = (t1cfg.timer_mode_register == T1_MODE_8AR);
  wire t1_ovf = t1_inc & (t1cfg.timer1_count_low == 8'hff) &
                (t1_ar | t1cfg.timer1_high_reload_byte == 8'hff);
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      t1cfg <= T1CFG_RST;
    end else if (wr_en && aw_addr == ADDR_T1CFG) begin
      t1cfg <= 20'(spb_merge({12'h0, t1cfg}, w_data, w_strb));
    end else if (t1_ovf && t1_ar) begin
      t1cfg.timer1_count_low <= t1cfg.timer1_high_reload_byte;
    end else if (t1_inc && t1_ar) begin
      t1cfg.timer1_count_low <= t1cfg.timer1_count_low + 8'h01;
    end else if (t1_inc && t1cfg.timer_mode_register == T1_MODE_16) begin
      // Software reloads this form from its own interrupt handler
      {t1cfg.timer1_high_reload_byte, t1cfg.timer1_count_low} <=
        {t1cfg.timer1_high_reload_byte, t1cfg.timer1_count_low} + 16'h0001;
    end
  end

  // Overflow halver; double-rate bit bypasses it, giving /16 not /32
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      t1_half <= 1'b0;
    end else if (t1_ovf) begin
      t1_half <= ~t1_half;
    end
  end
  wire t1_tick16 = t1_ovf & (t1cfg.double_rate | t1_half);

  // Timer 2 increment source: state time as bit-rate source
  wire t2_inc = t2ctl.timer2_run_bit & (t2ctl.timer2_counter_select ?
                t2pin_fall : (brg ? ph[0] : cyc_end));
  wire t2_ovf = t2_inc & (t2_count == 16'hffff);
  wire timer2_external_input_hit = timer2_external_input_fall & t2ctl.timer2_external_enable;
  wire t2_cnt_wr = wr_en & (aw_addr == ADDR_T2CNT);

  // Timer 2 count and reload pair; reload on every rollover, on external edge only outside bit-rate mode
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      t2_count <= T2CNT_RST;
      t2_reload <= T2CNT_RST;
    end else begin
      if (wr_en && aw_addr == ADDR_T2RLD) begin
        t2_reload <= 16'(spb_merge({16'h0, t2_reload}, w_data, w_strb));
      end
      // Software write wins here; it should stop the timer first
      if (t2_cnt_wr) begin
        t2_count <= 16'(spb_merge({16'h0, t2_count}, w_data, w_strb));
      end else if (t2_ovf || (timer2_external_input_hit && !brg)) begin
        t2_count <= t2_reload;
      end else if (t2_inc) begin
        t2_count <= t2_count + 16'h0001;
      end
    end
  end

  // Timer 2 control; hardware flag set beats a software clear
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      t2ctl <= T2CTL_RST;
    end else begin
      if (wr_at && aw_addr == ADDR_T2CTL) begin
        t2ctl <= w_data[7:0];
      end
      if (t2_ovf && !brg) begin
        t2ctl.timer2_overflow_flag <= 1'b1;
      end
      if (timer2_external_input_hit) begin
        t2ctl.timer2_external_flag <= 1'b1;
      end
    end
  end

  // Per-direction bit-rate source
  wire tx_tick16 = t2ctl.transmit_clock_select ? t2_ovf : t1_tick16;
  wire rx_tick16 = t2ctl.rx_clock_select ? t2_ovf : t1_tick16;
  wire tx_bit = tx_tick16 & (tx_div == DIV_LAST);
  wire rx_edge = rx_tick16 & rx_prev & ~din;
  wire rx_hunt_edge = is_m1 & (rx_state == RX_IDLE) &
                      sctrl.receive_enable & rx_edge;

  // Divide-by-16 counters; receive side restarts on a start edge
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tx_div <= 4'h0;
      rx_div <= 4'h0;
      rx_prev <= 1'b1;
    end else begin
      if (tx_tick16) begin
        tx_div <= tx_div + 4'h1;
      end
      if (rx_hunt_edge) begin
        rx_div <= 4'h0;
      end else if (rx_tick16) begin
        rx_div <= rx_div + 4'h1;
      end
      if (rx_tick16) begin
        rx_prev <= din;
      end
    end
  end

  // Completion strobes shared by flag, buffer and checking logic
  wire tx_marker = (tx_sh[8:1] == TX_MARK);
  wire xmit_flag_set = (tx_state == TX_SEND) && (is_m0
                       ? (ph == PH_S1P1 && tx_last)
                       : (tx_bit && tx_data_on && tx_marker));
  wire rx_bit_end = rx_tick16 & (rx_div == DIV_LAST);
  wire rx_vote = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
  wire rx1_final = is_m1 & (rx_state == RX_BUSY) & rx_bit_end &
                   ~rx_sh[0];
  wire rx1_keep = rx1_final & ~sctrl.receive_flag &
                  (~sctrl.multiprocessor_bit | rx_vote);
  wire recv_flag_set = rx1_keep | (is_m0 && rx_state == RX_BUSY &&
                       ph == PH_S1P1 && rx_last);

  // Transmitter: mode 0 on the machine cycle, mode 1 on rollovers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tx_state <= TX_IDLE;
      tx_sh <= 9'h000;
      tx_data_on <= 1'b0;
      tx_last <= 1'b0;
    end else if (buf_wr) begin
      tx_sh <= {1'b1, w_data[7:0]};
      tx_data_on <= 1'b0;
      tx_last <= 1'b0;
      tx_state <= (is_m0 && cyc_end) ? TX_ARM : TX_WAIT;
    end else begin
      case (tx_state)
        TX_WAIT: begin
          if (is_m0 ? cyc_end : tx_bit) begin
            tx_state <= TX_ARM;
          end
        end
        TX_ARM: begin
          // Mode 0 sends one machine cycle later, mode 1 at next S1P1
          if (is_m0 ? cyc_end : (ph == PH_S1P1)) begin
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (is_m0) begin
            if (xmit_flag_set) begin
              tx_state <= TX_IDLE;
              tx_last <= 1'b0;
            end else if (cyc_end) begin
              tx_sh <= {1'b0, tx_sh[8:1]};
              tx_last <= tx_marker;
            end
          end else if (tx_bit) begin
            if (!tx_data_on) begin
              tx_data_on <= 1'b1;
            end else begin
              tx_sh <= {1'b0, tx_sh[8:1]};
              if (tx_marker) begin
                tx_state <= TX_IDLE;
                tx_data_on <= 1'b0;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receiver: mode 0 shift sequencer and mode 1 edge-hunting deframer
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rx_state <= RX_IDLE;
      rx_sh <= 9'h000;
      rx_last <= 1'b0;
      smp <= 3'h7;
      m0_sample <= 1'b1;
      serial_buffer_rx <= 8'h00;
    end else if (is_m0) begin
      if (ph == PH_S5P2) begin
        m0_sample <= din;
      end
      case (rx_state)
        RX_IDLE: begin
          if (sctrl.receive_enable && !sctrl.receive_flag) begin
            rx_state <= RX_ARM;
          end
        end
        RX_ARM: begin
          if (ph == PH_S1P1) begin
            rx_state <= RX_NEXT;
          end
        end
        RX_NEXT: begin
          if (cyc_end) begin
            rx_sh <= RX0_INIT;
            rx_last <= 1'b0;
            rx_state <= RX_BUSY;
          end
        end
        RX_BUSY: begin
          if (recv_flag_set) begin
            rx_state <= RX_IDLE;
          end else if (cyc_end) begin
            // Shifts toward bit 0 so the first bit lands in the LSB
            rx_sh <= {1'b0, m0_sample, rx_sh[7:1]};
            rx_last <= ~rx_sh[0];
            if (!rx_sh[0]) begin
              serial_buffer_rx <= {m0_sample, rx_sh[7:1]};
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end else if (is_m1) begin
      if (rx_hunt_edge) begin
        rx_sh <= RX1_INIT;
        rx_state <= RX_BUSY;
      end else if (rx_state == RX_BUSY && rx_tick16) begin
        if (rx_div == SMP_FIRST || rx_div == SMP_MID || rx_div == SMP_LAST) begin
          smp <= {smp[1:0], din};
        end
        if (rx_bit_end) begin
          if (rx_sh == RX1_INIT && rx_vote) begin
            rx_state <= RX_IDLE;
          end else if (rx1_final) begin
            rx_state <= RX_IDLE;
            if (rx1_keep) begin
              serial_buffer_rx <= rx_sh[8:1];
            end
          end else begin
            rx_sh <= {rx_vote, rx_sh[8:1]};
          end
        end
      end else if (rx_state != RX_BUSY) begin
        rx_state <= RX_IDLE;
      end
    end else begin
      rx_state <= RX_IDLE;
    end
  end

  // Control register; a flag set in the cycle of its clear still wins
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sctrl <= SCTRL_RST;
    end else begin
      if (wr_at && aw_addr == ADDR_SCTRL) begin
        sctrl <= w_data[7:0];
      end
      if (xmit_flag_set) begin
        sctrl.transmit_flag <= 1'b1;
      end
      if (recv_flag_set) begin
        sctrl.receive_flag <= 1'b1;
      end
      if (rx1_keep) begin
        sctrl.received_ninth_bit <= rx_vote;
      end
    end
  end

  // Registered pin drivers; shift clock low from S3P1 until S6P1
  wire clk_low = (ph >= PH_S3P1) && (ph < PH_S6P1);
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      serial_data_pin_out <= 1'b1;
      serial_data_pin_oe_out <= 1'b0;
      serial_clock_pin_out <= 1'b1;
    end else if (is_m0) begin
      serial_data_pin_out <= tx_sh[0];
      serial_data_pin_oe_out <= (tx_state == TX_SEND);
      serial_clock_pin_out <= ~(((tx_state == TX_SEND) ||
                               (rx_state == RX_BUSY)) && clk_low);
    end else begin
      serial_data_pin_out <= 1'b1;
      serial_data_pin_oe_out <= 1'b0;
      serial_clock_pin_out <= (tx_state != TX_SEND) ? 1'b1 :
                              (tx_data_on ? tx_sh[0] : 1'b0);
    end
  end

  default clocking spb_cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  AST_M0_CLK_LOW: assert property (
    is_m0 && tx_state == TX_SEND && ph == 4'h5 |=> !serial_clock_pin_out)
    else $error("shift clock not low in S4");
  AST_M0_DRIVE: assert property (
    is_m0 && tx_state == TX_SEND && !buf_wr |=> serial_data_pin_oe_out)
    else $error("mode 0 send without data drive");
  AST_M0_TX_TIME: assert property (
    is_m0 && tx_state == TX_IDLE && buf_wr ##1 (is_m0 && !buf_wr)[*8]
    |-> ##[100:112] xmit_flag_set)
    else $error("mode 0 transmit flag late");
  AST_M0_RX_TIME: assert property (
    is_m0 && rx_state == RX_IDLE && sctrl.receive_enable &&
    !sctrl.receive_flag ##1 is_m0[*8] |-> ##[101:112] recv_flag_set)
    else $error("mode 0 receive flag late");
  AST_RX_RESTART: assert property (
    rx_hunt_edge |=> rx_div == 4'h0 && rx_sh == RX1_INIT)
    else $error("edge did not restart receiver");
  AST_FALSE_START: assert property (
    is_m1 && rx_state == RX_BUSY && rx_bit_end && rx_sh == RX1_INIT &&
    rx_vote |=> rx_state == RX_IDLE && !sctrl.receive_flag)
    else $error("false start not rejected");
  AST_RX_GATE: assert property (
    rx1_final && sctrl.receive_flag |-> !recv_flag_set)
    else $error("frame kept while flag set");
  AST_NO_TF2: assert property (
    brg && t2_ovf && !wr_en |=> $stable(t2ctl.timer2_overflow_flag))
    else $error("bit-rate rollover touched overflow flag");
  AST_T2_RELOAD: assert property (
    t2_ovf && !t2_cnt_wr |=> t2_count == $past(t2_reload))
    else $error("timer 2 rollover did not reload");
  AST_EXT_NO_RELOAD: assert property (
    brg && timer2_external_input_hit && !t2_ovf && !t2_cnt_wr && !t2_inc
    |=> t2ctl.timer2_external_flag && $stable(t2_count))
    else $error("external edge in bit-rate mode misbehaved");

  COV_M0_TX: cover property (is_m0 && xmit_flag_set);
  COV_M1_RX: cover property (rx1_keep);
  COV_M1_TX: cover property (is_m1 && xmit_flag_set);
endmodule : spb_serial_port

// ### design/spb_pkg.sv
/*
  Shared definitions for the serial port block: register offsets, reset
  values, machine-cycle phase numbers, field layouts and state encodings.
  Assumes one oscillator period per sys_clk_in cycle.
*/
package spb_pkg;
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_SCTRL = 8'h00;
  localparam logic [7:0] ADDR_SBUFR = 8'h04;
  localparam logic [7:0] ADDR_T2CTL = 8'h08;
  localparam logic [7:0] ADDR_T2CNT = 8'h0c;
  localparam logic [7:0] ADDR_T2RLD = 8'h10;
  localparam logic [7:0] ADDR_T1CFG = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [7:0] SCTRL_RST = 8'h00;
  localparam logic [7:0] T2CTL_RST = 8'h00;
  localparam logic [19:0] T1CFG_RST = 20'h00000;
  localparam logic [15:0] T2CNT_RST = 16'h0000;
  // Phase index in a twelve-clock machine cycle, S1P1 = 0 .. S6P2 = 11
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'ha;
  localparam logic [3:0] PH_S6P2 = 4'hb;
  // Divide-by-16 counter states
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] SMP_FIRST = 4'h6;
  localparam logic [3:0] SMP_MID = 4'h7;
  localparam logic [3:0] SMP_LAST = 4'h8;
  // Shift register preloads and end markers
  localparam logic [8:0] RX0_INIT = 9'h07f;
  localparam logic [8:0] RX1_INIT = 9'h1ff;
  localparam logic [7:0] TX_MARK = 8'h01;
  localparam logic [1:0] T1_MODE_16 = 2'b01;
  localparam logic [1:0] T1_MODE_8AR = 2'b10;
  localparam logic [1:0] SP_MODE_SHIFT = 2'b00;

  typedef struct packed {
    logic [1:0] port_mode;
    logic multiprocessor_bit;
    logic receive_enable;
    logic ninth_tx_bit;
    logic received_ninth_bit;
    logic transmit_flag;
    logic receive_flag;
  } spb_sctrl_t;

  typedef struct packed {
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic rx_clock_select;
    logic transmit_clock_select;
    logic timer2_external_enable;
    logic timer2_run_bit;
    logic timer2_counter_select;
    logic capture_select;
  } spb_t2ctl_t;

  typedef struct packed {
    logic double_rate;
    logic timer1_run;
    logic [1:0] timer_mode_register;
    logic [7:0] timer1_high_reload_byte;
    logic [7:0] timer1_count_low;
  } spb_t1cfg_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_ARM = 2'b10, TX_SEND = 2'b11
  } spb_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_ARM = 2'b01, RX_NEXT = 2'b10, RX_BUSY = 2'b11
  } spb_rx_state_t;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] spb_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : spb_merge
endpackage : spb_pkg

// ### bench/spb_far_port.sv
/* Far-side serial port model: mode 1 framer and deframer.
   Assumes idle-high lines and BIT_NS equal to the port's bit time. */
`timescale 1ns/1ps
module spb_far_port #(parameter int BIT_NS = 1280) (
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] last_rx;
  int rx_count;
  initial begin
    line_out = 1'b1;
    rx_count = 0;
  end
  // Start low, data LSB first, stop level chosen by caller
  task automatic send(input logic [7:0] d, input logic stop);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = stop;
    #(BIT_NS);
    line_out = 1'b1;
  endtask : send
  // Mid-bit sampling; busy block ignores edges inside a frame
  always @(negedge line_in) begin
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      last_rx[i] = line_in;
      #(BIT_NS);
    end
    rx_count++;
  end
endmodule : spb_far_port

// ### bench/testbench.sv
/* Self-checking bench: AXI4-Lite tasks, mode 1 traffic via timer 2.
   Assumes the far-port model sits on the mode 1 line pair. */
`timescale 1ns/1ps
module testbench;
  import spb_pkg::*;
  logic clk = 0, rstn = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, rd;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, rx_line, tx_line, ta, tw;
  logic [1:0] b_resp, r_resp, resp;
  logic [31:0] r_d;
  logic m0_d, m0_oe;
  logic [7:0] m0_cap = 0;
  int n_mismatch = 0, samples_checked = 0;
  spb_serial_port u_dut (.sys_clk_in(clk), .resetn_in(rstn),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_rdy),
    .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a),
    .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_rdy),
    .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_resp),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r),
    .serial_data_pin_in(rx_line), .serial_data_pin_out(m0_d),
    .serial_data_pin_oe_out(m0_oe), .serial_clock_pin_out(tx_line),
    .timer2_external_input_in(1'b1), .timer2_count_pin_in(1'b1));
  // Reload fffb: five increments of two clocks per tick, 160 clocks a bit
  spb_far_port #(.BIT_NS(1280)) u_far (.line_in(tx_line),
    .line_out(rx_line));
  initial forever #4 clk = ~clk;
  // Mode 0 external shift register: takes data on the rising shift clock
  always @(posedge tx_line) begin
    if (m0_oe === 1'b1) m0_cap <= {m0_d, m0_cap[7:1]};
  end
  // Mismatch reporting and tally
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Ready sampled mid-cycle, valid dropped after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_a <= a; w_d <= d; aw_v <= 1; w_v <= 1; b_r <= 1;
    do begin
      @(negedge clk);
      ta = aw_rdy & aw_v;
      tw = w_rdy & w_v;
      @(posedge clk);
      if (ta) aw_v <= 0;
      if (tw) w_v <= 0;
    end while (!(ta | !aw_v) || !(tw | !w_v));
    do @(negedge clk); while (!b_v);
    @(posedge clk);
    resp = b_resp;
    b_r <= 0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a; ar_v <= 1; r_r <= 1;
    do @(negedge clk); while (!ar_rdy);
    @(posedge clk);
    ar_v <= 0;
    do @(negedge clk); while (!r_v);
    @(posedge clk);
    rd = r_d; resp = r_resp;
    r_r <= 0;
  endtask : rd_reg
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #400_000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd_reg(ADDR_SCTRL);
    chk("sctrl reset", rd, 32'(SCTRL_RST));
    rd_reg(8'h40);
    chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
    $display("test reset done");
    // Timer 2 set up while stopped, then both directions selected
    wr(ADDR_T2RLD, 32'h0000fffb);
    wr(ADDR_T2CNT, 32'h0000fffb);
    wr(ADDR_T2CTL, 32'h00000034);
    wr(ADDR_SCTRL, 32'h00000050);
    u_far.send(8'ha5, 1'b1);
    for (int i = 0; i < 1000 && !rd[0]; i++) rd_reg(ADDR_SCTRL);
    chk("sctrl after rx", rd, 32'h00000055);
    rd_reg(ADDR_SBUFR);
    chk("rx byte", rd, 32'h000000a5);
    rd_reg(ADDR_T2CTL);
    chk("t2 no overflow flag", rd, 32'h00000034);
    $display("test receive done");
    // Missing stop with multiprocessor bit set: frame must be dropped
    wr(ADDR_SCTRL, 32'h00000070);
    u_far.send(8'h5a, 1'b0);
    repeat (400) @(posedge clk);
    rd_reg(ADDR_SCTRL);
    chk("sctrl after bad stop", rd, 32'h00000070);
    rd_reg(ADDR_SBUFR);
    chk("buffer kept", rd, 32'h000000a5);
    $display("test drop done");
    wr(ADDR_SBUFR, 32'h0000003c);
    rd = 0;
    for (int i = 0; i < 1000 && !rd[1]; i++) rd_reg(ADDR_SCTRL);
    chk("tx flag", rd, 32'h00000072);
    repeat (200) @(posedge clk);
    chk("far rx byte", 32'(u_far.last_rx), 32'h0000003c);
    $display("test transmit done");
    // Mode 0 send into the bench's shift register, receiver disabled
    wr(ADDR_SCTRL, 32'h00000000);
    wr(ADDR_SBUFR, 32'h00000096);
    rd = 0;
    for (int i = 0; i < 1000 && !rd[1]; i++) rd_reg(ADDR_SCTRL);
    chk("m0 tx flag", rd, 32'h00000002);
    chk("m0 shifted byte", 32'(m0_cap), 32'h00000096);
    $display("test mode 0 done");
    tally_and_finish();
  end
endmodule : testbench
